// ==== core/kbd_edge_detect.sv ====
`timescale 1ns/1ps
// rising edge detector for the two keyboard controller lines
module kbd_edge_detect
   import kbd_emul_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_level,
   output logic o_rise
);
   logic last_r;
   logic last_nxt;

   // remember the previous level; inputs are synchronous already
   always_comb begin
      last_nxt = i_level;
   end

   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         last_r <= 1'b0;
      end else begin
         last_r <= last_nxt;
      end
   end

   assign o_rise = i_level & ~last_r;
endmodule

// ==== core/kbd_emul_pkg.sv ====
package kbd_emul_pkg;
   // ----------------------------------------------------------------
   // control register field positions
   // ----------------------------------------------------------------
   localparam int BIT_EMUL_ON = 0;
   localparam int BIT_EMUL_IRQ_STATUS = 1;
   localparam int BIT_CHAR_WAITING = 2;
   localparam int BIT_KBD_LINE_ENABLE = 3;
   localparam int BIT_EXT_TRIGGER_ENABLE = 4;
   localparam int BIT_GATE_CMD_SEQUENCE = 5;
   localparam int BIT_KBD_EDGE_SEEN = 6;
   localparam int BIT_AUX_EDGE_SEEN = 7;
   localparam int BIT_ADDR_GATE_STATUS = 8;
   localparam int CTRL_USED_BITS = 9;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ----------------------------------------------------------------
   // legacy port addresses and command codes
   // ----------------------------------------------------------------
   localparam logic [15:0] PORT_DATA = 16'h0060;
   localparam logic [15:0] PORT_CMD = 16'h0064;
   localparam logic [7:0] CMD_GATE_WRITE = 8'hd1;
endpackage

// ==== core/legacy_keyboard_emulation_ctrl.sv ====
`timescale 1ns/1ps
module legacy_keyboard_emulation_ctrl
   import kbd_emul_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   // control register access from the target path
   input wire logic i_ctrl_wr,
   input wire logic [31:0] i_ctrl_wdata,
   // status flags written by emulation software
   input wire logic i_status_wr,
   input wire logic i_out_buf_full_wdata,
   input wire logic i_aux_out_buf_full_wdata,
   input wire logic i_in_buf_full_wdata,
   input wire logic i_cmd_or_data_flag_wdata,
   // host legacy port I/O cycle
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [15:0] i_io_addr,
   input wire logic [7:0] i_io_wdata,
   // lines from the external keyboard controller
   input wire logic i_keyboard_intr_line,
   input wire logic i_aux_intr_line,
   output logic [31:0] o_ctrl_rdata,
   output logic o_out_buf_full,
   output logic o_aux_out_buf_full,
   output logic o_in_buf_full,
   output logic o_cmd_or_data_flag,
   output logic o_keyboard_intr_line,
   output logic o_aux_intr_line,
   output logic o_emul_irq,
   output logic o_addr_line_gate,
   output logic o_io_claim
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // stored control bits, written by software
   logic emul_on_r, emul_on_nxt;
   logic char_waiting_r, char_waiting_nxt;
   logic kbd_line_enable_r, kbd_line_enable_nxt;
   logic ext_en_r, ext_en_nxt;
   logic gate_seq_r, gate_seq_nxt;
   logic kbd_seen_r, kbd_seen_nxt;
   logic aux_seen_r, aux_seen_nxt;
   logic gate_stat_r, gate_stat_nxt;

   // status flags shared between host ports and emulation software
   logic obf_r, obf_nxt;
   logic aux_obf_r, aux_obf_nxt;
   logic ibf_r, ibf_nxt;
   logic cmd_flag_r, cmd_flag_nxt;

   // registered copies that feed the outputs
   logic irq_cond_r, irq_cond_nxt;
   logic kbd_out_r, kbd_out_nxt;
   logic aux_out_r, aux_out_nxt;
   logic gate_pin_r, gate_pin_nxt;
   logic claim_r, claim_nxt;
   logic [31:0] rdata_r, rdata_nxt;

   // combinational strobes from the edge detectors and the decode
   logic kbd_rise, aux_rise;
   logic hit_data, hit_cmd, gate_done;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   // the readback image is 32 bits wide and every stored field must
   // sit below the reserved range, or bits 31:9 would not read zero
   if (CTRL_USED_BITS > 32) begin : g_bad_width
      $error("control image wider than the register");
   end
   if (BIT_ADDR_GATE_STATUS >= CTRL_USED_BITS) begin : g_bad_field
      $error("control field inside the reserved range");
   end

   // ----------------------------------------------------------------
   // shared decode helpers
   // ----------------------------------------------------------------
   // a legacy port only answers while emulation is on; folding the
   // enable into the compare keeps the two ports from drifting apart
   function automatic logic port_hit(input logic en,
      input logic [15:0] addr, input logic [15:0] port);
      return en && (addr == port);
   endfunction

   // both emulated lines need the enable and a full output buffer;
   // the auxiliary flag alone decides which of the two is driven
   function automatic logic line_level(input logic on, input logic en,
      input logic full, input logic aux, input logic want_aux);
      return on && en && full && (aux == want_aux);
   endfunction

   // ----------------------------------------------------------------
   // edge capture on the external controller lines
   // ----------------------------------------------------------------
   // line 1 from the external controller
   kbd_edge_detect u_kbd_edge (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_level(i_keyboard_intr_line),
      .o_rise(kbd_rise)
   );

   // line 12 from the external controller
   kbd_edge_detect u_aux_edge (
      .i_clock(i_clock),
      .i_rst_b(i_rst_b),
      .i_level(i_aux_intr_line),
      .o_rise(aux_rise)
   );

   // ----------------------------------------------------------------
   // port decode, only while emulation is on
   // ----------------------------------------------------------------
   always_comb begin
      hit_data = port_hit(emul_on_r, i_io_addr, PORT_DATA);
      hit_cmd = port_hit(emul_on_r, i_io_addr, PORT_CMD);
      // the data write that ends an address gate sequence is absorbed
      gate_done = hit_data && i_io_wr && gate_seq_r;
   end

   // ----------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------
   always_comb begin
      emul_on_nxt = emul_on_r;
      char_waiting_nxt = char_waiting_r;
      kbd_line_enable_nxt = kbd_line_enable_r;
      ext_en_nxt = ext_en_r;
      gate_seq_nxt = gate_seq_r;
      kbd_seen_nxt = kbd_seen_r;
      aux_seen_nxt = aux_seen_r;
      gate_stat_nxt = gate_stat_r;
      obf_nxt = obf_r;
      aux_obf_nxt = aux_obf_r;
      ibf_nxt = ibf_r;
      cmd_flag_nxt = cmd_flag_r;
      // software writes first; hardware events below take precedence
      // bit 1 and bits 31:9 are never stored; they are rebuilt below
      if (i_ctrl_wr) begin
         emul_on_nxt = i_ctrl_wdata[BIT_EMUL_ON];
         char_waiting_nxt = i_ctrl_wdata[BIT_CHAR_WAITING];
         kbd_line_enable_nxt = i_ctrl_wdata[BIT_KBD_LINE_ENABLE];
         ext_en_nxt = i_ctrl_wdata[BIT_EXT_TRIGGER_ENABLE];
         gate_seq_nxt = i_ctrl_wdata[BIT_GATE_CMD_SEQUENCE];
         gate_stat_nxt = i_ctrl_wdata[BIT_ADDR_GATE_STATUS];
         if (i_ctrl_wdata[BIT_KBD_EDGE_SEEN]) begin
            kbd_seen_nxt = 1'b0;
         end
         if (i_ctrl_wdata[BIT_AUX_EDGE_SEEN]) begin
            aux_seen_nxt = 1'b0;
         end
      end
      // the emulation software owns the buffer flags between accesses
      if (i_status_wr) begin
         obf_nxt = i_out_buf_full_wdata;
         aux_obf_nxt = i_aux_out_buf_full_wdata;
         ibf_nxt = i_in_buf_full_wdata;
         cmd_flag_nxt = i_cmd_or_data_flag_wdata;
      end
      // a new edge wins over a clear in the same cycle
      if (kbd_rise) begin
         kbd_seen_nxt = 1'b1;
      end
      if (aux_rise) begin
         aux_seen_nxt = 1'b1;
      end
      // a command byte restarts or ends the address gate sequence
      if (i_io_wr && hit_cmd) begin
         gate_seq_nxt = (i_io_wdata == CMD_GATE_WRITE);
         cmd_flag_nxt = 1'b1;
         ibf_nxt = 1'b1;
      end
      // a data byte fills the input buffer unless it ends the sequence
      if (i_io_wr && hit_data) begin
         cmd_flag_nxt = 1'b0;
         if (gate_done) begin
            // bit 1 of the data byte carries the requested gate level
            gate_stat_nxt = i_io_wdata[1];
            gate_seq_nxt = 1'b0;
         end else begin
            ibf_nxt = 1'b1;
         end
      end
      // the host has taken the byte, so the output buffer is free
      if (i_io_rd && hit_data) begin
         obf_nxt = 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // interrupt and output next values
   // ----------------------------------------------------------------
   always_comb begin
      // the external trigger lasts one cycle per edge; the edge-seen
      // bits keep the record for software that polls too late
      irq_cond_nxt = (char_waiting_nxt && !obf_nxt)
         || (emul_on_nxt && ibf_nxt)
         || (ext_en_nxt && (kbd_rise || aux_rise));
      kbd_out_nxt = line_level(emul_on_nxt, kbd_line_enable_nxt, obf_nxt,
         aux_obf_nxt, 1'b0);
      aux_out_nxt = line_level(emul_on_nxt, kbd_line_enable_nxt, obf_nxt,
         aux_obf_nxt, 1'b1);
      // the gate pin follows the stored status bit
      gate_pin_nxt = gate_stat_nxt;
      // tells the port bridge that this block answered the cycle
      claim_nxt = (hit_data || hit_cmd) && (i_io_wr || i_io_rd);
   end

   // ----------------------------------------------------------------
   // control register image
   // ----------------------------------------------------------------
   // built from next values so the readback never lags the state
   always_comb begin
      rdata_nxt = CTRL_RESET;
      rdata_nxt[BIT_EMUL_ON] = emul_on_nxt;
      rdata_nxt[BIT_EMUL_IRQ_STATUS] = irq_cond_nxt;
      rdata_nxt[BIT_CHAR_WAITING] = char_waiting_nxt;
      rdata_nxt[BIT_KBD_LINE_ENABLE] = kbd_line_enable_nxt;
      rdata_nxt[BIT_EXT_TRIGGER_ENABLE] = ext_en_nxt;
      rdata_nxt[BIT_GATE_CMD_SEQUENCE] = gate_seq_nxt;
      rdata_nxt[BIT_KBD_EDGE_SEEN] = kbd_seen_nxt;
      rdata_nxt[BIT_AUX_EDGE_SEEN] = aux_seen_nxt;
      rdata_nxt[BIT_ADDR_GATE_STATUS] = gate_stat_nxt;
   end

   // ----------------------------------------------------------------
   // registers, all clear at reset
   // ----------------------------------------------------------------
   // reset loads constants only, so the clear stays purely asynchronous
   always_ff @(posedge i_clock or negedge i_rst_b) begin
      if (!i_rst_b) begin
         emul_on_r <= 1'b0;
         char_waiting_r <= 1'b0;
         kbd_line_enable_r <= 1'b0;
         ext_en_r <= 1'b0;
         gate_seq_r <= 1'b0;
         kbd_seen_r <= 1'b0;
         aux_seen_r <= 1'b0;
         gate_stat_r <= 1'b0;
         obf_r <= 1'b0;
         aux_obf_r <= 1'b0;
         ibf_r <= 1'b0;
         cmd_flag_r <= 1'b0;
         irq_cond_r <= 1'b0;
         kbd_out_r <= 1'b0;
         aux_out_r <= 1'b0;
         gate_pin_r <= 1'b0;
         claim_r <= 1'b0;
         rdata_r <= CTRL_RESET;
      end else begin
         emul_on_r <= emul_on_nxt;
         char_waiting_r <= char_waiting_nxt;
         kbd_line_enable_r <= kbd_line_enable_nxt;
         ext_en_r <= ext_en_nxt;
         gate_seq_r <= gate_seq_nxt;
         kbd_seen_r <= kbd_seen_nxt;
         aux_seen_r <= aux_seen_nxt;
         gate_stat_r <= gate_stat_nxt;
         obf_r <= obf_nxt;
         aux_obf_r <= aux_obf_nxt;
         ibf_r <= ibf_nxt;
         cmd_flag_r <= cmd_flag_nxt;
         irq_cond_r <= irq_cond_nxt;
         kbd_out_r <= kbd_out_nxt;
         aux_out_r <= aux_out_nxt;
         gate_pin_r <= gate_pin_nxt;
         claim_r <= claim_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // ----------------------------------------------------------------
   // outputs straight from flip-flops
   // ----------------------------------------------------------------
   assign o_ctrl_rdata = rdata_r;
   assign o_out_buf_full = obf_r;
   assign o_aux_out_buf_full = aux_obf_r;
   assign o_in_buf_full = ibf_r;
   assign o_cmd_or_data_flag = cmd_flag_r;
   assign o_keyboard_intr_line = kbd_out_r;
   assign o_aux_intr_line = aux_out_r;
   assign o_emul_irq = irq_cond_r;
   assign o_addr_line_gate = gate_pin_r;
   assign o_io_claim = claim_r;
endmodule

// ==== test/kbd_ctrl_model.sv ====
`timescale 1ns/1ps
// external keyboard controller: two interrupt levels, idle low
module kbd_ctrl_model (
   input wire logic i_clock,
   output logic o_keyboard_intr_line,
   output logic o_aux_intr_line
);
   initial begin
      o_keyboard_intr_line = 1'b0;
      o_aux_intr_line = 1'b0;
   end
   // lines change just after an edge, like real controller outputs
   task set_line(input logic aux, input logic lvl);
      @(posedge i_clock);
      #1;
      if (aux) o_aux_intr_line = lvl;
      else o_keyboard_intr_line = lvl;
   endtask
endmodule

// ==== test/kbd_emul_monitor.sv ====
`timescale 1ns/1ps
// watches the control block from its ports only
module kbd_emul_monitor
   import kbd_emul_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_rst_b,
   input wire logic i_io_wr,
   input wire logic i_io_rd,
   input wire logic [15:0] i_io_addr,
   input wire logic [7:0] i_io_wdata,
   input wire logic i_keyboard_intr_line,
   input wire logic [31:0] o_ctrl_rdata,
   input wire logic o_out_buf_full,
   input wire logic o_aux_out_buf_full,
   input wire logic o_in_buf_full,
   input wire logic o_cmd_or_data_flag,
   input wire logic o_keyboard_intr_line,
   input wire logic o_emul_irq
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_rst_b);
   // port effects only count while emulation is on
   logic cmd_wr;
   assign cmd_wr = i_io_wr && o_ctrl_rdata[0] && i_io_addr == PORT_CMD;
   upper_zero_a: assert property (o_ctrl_rdata[31:9] == 23'h0)
      else $error("reserved control bits not zero");
   status_mirror_a: assert property (o_ctrl_rdata[1] == o_emul_irq)
      else $error("status bit differs from interrupt");
   gate_set_a: assert property (cmd_wr
      && i_io_wdata == CMD_GATE_WRITE |=> o_ctrl_rdata[5])
      else $error("gate sequence not set");
   gate_clear_a: assert property (cmd_wr
      && i_io_wdata != CMD_GATE_WRITE |=> !o_ctrl_rdata[5])
      else $error("gate sequence not cleared");
   in_full_set_a: assert property (cmd_wr |=> o_in_buf_full)
      else $error("input full not set");
   data_flag_a: assert property (i_io_wr && o_ctrl_rdata[0]
      && i_io_addr == PORT_DATA |=> !o_cmd_or_data_flag)
      else $error("command flag not cleared");
   gate_done_a: assert property (i_io_wr && o_ctrl_rdata[0]
      && o_ctrl_rdata[5] && i_io_addr == PORT_DATA
      |=> o_ctrl_rdata[8] == $past(i_io_wdata[1]) && !o_ctrl_rdata[5])
      else $error("gate sequence did not complete");
   cmd_flag_a: assert property (cmd_wr |=> o_cmd_or_data_flag)
      else $error("command flag not set");
   out_clear_a: assert property (i_io_rd && o_ctrl_rdata[0]
      && i_io_addr == PORT_DATA |=> !o_out_buf_full)
      else $error("output full not cleared");
   kbd_line_a: assert property (o_keyboard_intr_line ==
      (o_ctrl_rdata[0] && o_ctrl_rdata[3] && o_out_buf_full
      && !o_aux_out_buf_full)) else $error("keyboard line wrong");
   in_full_irq_a: assert property (o_ctrl_rdata[0] && o_in_buf_full
      |-> o_emul_irq) else $error("input full irq missing");
   char_irq_a: assert property (o_ctrl_rdata[2] && !o_out_buf_full
      |-> o_emul_irq) else $error("character irq missing");
   edge_seen_a: assert property ($rose(i_keyboard_intr_line)
      |-> ##[1:2] o_ctrl_rdata[6]) else $error("line edge not latched");
endmodule

// ==== test/legacy_keyboard_emulation_ctrl_tb.sv ====
`timescale 1ns/1ps
module legacy_keyboard_emulation_ctrl_tb;
   import kbd_emul_pkg::*;
   logic i_clock = 0, i_rst_b = 0, i_ctrl_wr = 0, i_status_wr = 0;
   logic [31:0] i_ctrl_wdata = 0, o_ctrl_rdata;
   logic [3:0] sw = 0;
   logic i_io_wr = 0, i_io_rd = 0, kl, al, o_ofull, o_aofull, o_ifull;
   logic [15:0] i_io_addr = 0;
   logic [7:0] i_io_wdata = 0;
   logic o_cmd, o_kl, o_al, o_emul_irq, o_gate, o_claim, claim_seen;
   int num_errors = 0, checks = 0, cyc = 0;
   always #2 i_clock = ~i_clock;
   kbd_ctrl_model kbc(.i_clock(i_clock), .o_keyboard_intr_line(kl),
      .o_aux_intr_line(al));
   legacy_keyboard_emulation_ctrl uut(.i_clock(i_clock), .i_rst_b(i_rst_b),
      .i_ctrl_wr(i_ctrl_wr), .i_ctrl_wdata(i_ctrl_wdata),
      .i_status_wr(i_status_wr), .i_out_buf_full_wdata(sw[3]),
      .i_aux_out_buf_full_wdata(sw[2]), .i_in_buf_full_wdata(sw[1]),
      .i_cmd_or_data_flag_wdata(sw[0]), .i_io_wr(i_io_wr),
      .i_io_rd(i_io_rd), .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata),
      .i_keyboard_intr_line(kl), .i_aux_intr_line(al),
      .o_ctrl_rdata(o_ctrl_rdata), .o_out_buf_full(o_ofull),
      .o_aux_out_buf_full(o_aofull), .o_in_buf_full(o_ifull),
      .o_cmd_or_data_flag(o_cmd), .o_keyboard_intr_line(o_kl),
      .o_aux_intr_line(o_al), .o_emul_irq(o_emul_irq),
      .o_addr_line_gate(o_gate), .o_io_claim(o_claim));
   // ---------------------------------------------------------------
   // access tasks
   // ---------------------------------------------------------------
   task test_done;
      if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task tick;
      @(posedge i_clock);
      #1;
   endtask
   // each access ends with one idle edge, so a strobe never drops and
   // rises again in the same time step on back-to-back calls
   task cw(input logic [31:0] d);
      i_ctrl_wr = 1;
      i_ctrl_wdata = d;
      tick;
      i_ctrl_wr = 0;
      tick;
   endtask
   task stw(input logic [3:0] d);
      i_status_wr = 1;
      sw = d;
      tick;
      i_status_wr = 0;
      tick;
   endtask
   // the claim stands for one cycle only, so it is caught right away
   task io(input logic wr, input logic [15:0] a, input logic [7:0] d);
      i_io_wr = wr;
      i_io_rd = !wr;
      i_io_addr = a;
      i_io_wdata = d;
      tick;
      i_io_wr = 0;
      i_io_rd = 0;
      claim_seen = o_claim;
      tick;
   endtask
   // the trigger is a single-cycle pulse, so poll for it briefly
   task wirq;
      int n;
      n = 0;
      while (o_emul_irq !== 1'b1 && n < 4) begin
         tick;
         n++;
      end
      chk("irq", 1, o_emul_irq);
   endtask
   // hang guard: the whole run needs well under 200 cycles
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 2000) begin
         num_errors++;
         test_done;
      end
   end
   initial begin
      repeat (20) @(posedge i_clock);
      #1;
      i_rst_b = 1;
      chk("ctrl", 0, o_ctrl_rdata);
      io(1, PORT_CMD, 8'hd1);
      chk("in_full", 0, o_ifull);
      chk("claim", 0, claim_seen);
      cw(32'hffff_fe03);
      chk("ctrl", 32'h1, o_ctrl_rdata);
      io(1, PORT_CMD, 8'hd1);
      chk("claim", 1, claim_seen);
      chk("ctrl", 32'h23, o_ctrl_rdata);
      chk("irq", 1, o_emul_irq);
      chk("cmd", 1, o_cmd);
      chk("in_full", 1, o_ifull);
      io(1, PORT_DATA, 8'h02);
      chk("ctrl", 32'h103, o_ctrl_rdata);
      chk("gate", 1, o_gate);
      chk("cmd", 0, o_cmd);
      io(1, PORT_CMD, 8'hd1);
      chk("ctrl", 32'h123, o_ctrl_rdata);
      io(1, PORT_CMD, 8'hff);
      chk("ctrl", 32'h103, o_ctrl_rdata);
      stw(4'h8);
      cw(32'h109);
      chk("ctrl", 32'h109, o_ctrl_rdata);
      chk("kbd", 1, o_kl);
      chk("aux", 0, o_al);
      stw(4'hc);
      chk("aux_full", 1, o_aofull);
      chk("kbd", 0, o_kl);
      chk("aux", 1, o_al);
      io(0, PORT_DATA, 8'h00);
      chk("claim", 1, claim_seen);
      chk("out_full", 0, o_ofull);
      chk("aux", 0, o_al);
      cw(32'h105);
      chk("ctrl", 32'h107, o_ctrl_rdata);
      cw(32'h10);
      kbc.set_line(0, 1);
      wirq();
      chk("kseen", 1, o_ctrl_rdata[6]);
      kbc.set_line(0, 0);
      cw(32'h10);
      chk("ctrl", 32'h50, o_ctrl_rdata);
      cw(32'h50);
      chk("ctrl", 32'h10, o_ctrl_rdata);
      kbc.set_line(1, 1);
      wirq();
      kbc.set_line(1, 0);
      cw(32'h10);
      chk("ctrl", 32'h90, o_ctrl_rdata);
      cw(32'h90);
      chk("ctrl", 32'h10, o_ctrl_rdata);
      cw(32'h0);
      kbc.set_line(0, 1);
      tick;
      chk("irq", 0, o_emul_irq);
      chk("ctrl", 32'h40, o_ctrl_rdata);
      test_done;
   end
endmodule
bind legacy_keyboard_emulation_ctrl kbd_emul_monitor mon(.i_clock(i_clock),
   .i_rst_b(i_rst_b), .i_io_wr(i_io_wr), .i_io_rd(i_io_rd),
   .i_io_addr(i_io_addr), .i_io_wdata(i_io_wdata),
   .i_keyboard_intr_line(i_keyboard_intr_line), .o_ctrl_rdata(o_ctrl_rdata),
   .o_out_buf_full(o_out_buf_full), .o_aux_out_buf_full(o_aux_out_buf_full),
   .o_in_buf_full(o_in_buf_full), .o_cmd_or_data_flag(o_cmd_or_data_flag),
   .o_keyboard_intr_line(o_keyboard_intr_line), .o_emul_irq(o_emul_irq));
